// *** hdl/status_pkg.sv ***
// Package with constants and types for the status LED and fault signalling block.
package status_pkg;

	// Blink timing: a blink rate of about one hertz at the 125 MHz system clock.
	localparam int CLK_HZ = 125000000;
	localparam int BLINK_HZ = 1;
	localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);

	// Low-power threshold in millivolts and the supply measurement width.
	localparam int VOLT_W = 16;
	localparam logic [15:0] LOW_POWER_MV = 16'h2AF8;

	// Error source bit positions inside the error vector.
	localparam int ERR_W = 5;
	localparam int ERR_STEP_LOSS = 0;
	localparam int ERR_OVERTEMP = 1;
	localparam int ERR_LOW_POWER = 2;
	localparam int ERR_OVERCURRENT = 3;
	localparam int ERR_OTHER = 4;

	// Warning source bit positions inside the warning vector.
	localparam int WARN_W = 2;
	localparam int WARN_OVERLOAD = 0;
	localparam int WARN_OTHER = 1;

	// Interrupt status and mask bit positions.
	localparam int IRQ_W = 4;
	localparam int IRQ_ERROR = 0;
	localparam int IRQ_WARNING = 1;
	localparam int IRQ_ACK = 2;
	localparam int IRQ_UPDATE = 3;

	// Register offsets on the plain register port.
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_IRQ_STATUS = 4'h1;
	localparam logic [3:0] REG_IRQ_MASK = 4'h2;
	localparam logic [3:0] REG_CONTROL = 4'h3;
	localparam logic [3:0] REG_MASTER_PIN = 4'h4;
	localparam logic [3:0] REG_PIN_ENTRY = 4'h5;
	localparam logic [3:0] REG_COMMAND = 4'h6;

	// Control register field positions.
	localparam int CTL_AUTO = 0;
	localparam int CTL_ACCESS_EN = 1;

	// Command register field positions (write one to trigger).
	localparam int CMD_FLASH = 0;
	localparam int CMD_DONE_OK = 1;
	localparam int CMD_TOOL_ACK = 2;

	// Reset values.
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] MASTER_PIN_RESET = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	// LED colour pins are red and green; orange lights both.
	typedef enum logic [4:0] {
		PAT_GREEN = 5'b00001,
		PAT_ORANGE = 5'b00010,
		PAT_RED = 5'b00100,
		PAT_ALT = 5'b01000,
		PAT_OFF = 5'b10000
	} pattern_t;

	// Firmware update sequence states.
	typedef enum logic [3:0] {
		UPD_IDLE = 4'b0001,
		UPD_RESTART = 4'b0010,
		UPD_LOAD = 4'b0100,
		UPD_REFRUN = 4'b1000
	} upd_state_t;

endpackage

// *** hdl/blink_timer.sv ***
// Common blink timer that toggles a phase bit every half blink period.
module blink_timer #(
	parameter int HALF_CYCLES = status_pkg::BLINK_HALF_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Blink phase, high during the lit half of the period.
	output logic phase
);
	import status_pkg::*;

	localparam int CW = $clog2(HALF_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic next_phase;

	// One shared period keeps every pattern in step, so the alternate pattern flips cleanly.
	always_comb begin
		next_count = count + CW'(1);
		next_phase = phase;
		if (count == LAST) begin
			next_count = '0;
			next_phase = ~phase;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count <= '0;
			phase <= 1'b0;
		end else begin
			count <= next_count;
			phase <= next_phase;
		end
	end
endmodule

// *** hdl/status_signal.sv ***
// Status LED, fault output, acknowledgement and firmware update sequencing for a stepper card.
module status_signal #(
	parameter int HALF_CYCLES = status_pkg::BLINK_HALF_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Operator buttons and master control.
	input wire logic btn_open,
	input wire logic btn_close,
	input wire logic ext_reset_in,
	// Condition sources from the motor control logic.
	input wire logic [status_pkg::ERR_W-1:0] err_event,
	input wire logic [status_pkg::WARN_W-1:0] warn_event,
	input wire logic critical_event,
	input wire logic [status_pkg::VOLT_W-1:0] supply_mv,
	input wire logic startup_done,
	input wire logic no_device_type,
	input wire logic device_changed,
	input wire logic refrun_needed,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Indicators and outputs.
	output logic led_red,
	output logic led_green,
	output logic fault_out,
	output logic fault_led,
	output logic irq,
	output logic restart_req,
	output logic refrun_start
);
	import status_pkg::*;

	// Blink phase shared by every pattern.
	logic phase;
	// Latched conditions: pending errors and warnings, tool acknowledges, critical and start-up latches.
	logic [ERR_W-1:0] err_pend, next_err_pend;
	logic [ERR_W-1:0] tool_acked, next_tool_acked;
	logic [WARN_W-1:0] warn_pend, next_warn_pend;
	logic critical, next_critical;
	logic startup_low, next_startup_low;
	// Software-visible registers and the one-shot PIN grant.
	logic [15:0] control, next_control;
	logic [15:0] master_pin, next_master_pin;
	logic pin_ok, next_pin_ok;
	logic [IRQ_W-1:0] irq_status, next_irq_status;
	logic [IRQ_W-1:0] irq_mask, next_irq_mask;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [15:0] rdata, next_rdata;
	// Update sequencer state.
	upd_state_t upd, next_upd;
	// Output flip-flops and their next values.
	logic red_q, green_q, next_red, next_green;
	logic fault_q, next_fault;
	logic restart_q, refrun_q;

	// Decoded conditions, recomputed every cycle.
	logic low_power; // Supply under the threshold this cycle.
	logic ack; // Any acknowledge source that clears errors.
	logic auto_mode; // Automatic mode from the control register.
	logic wr_cmd; // Write strobe aimed at the command register.
	logic flash_go; // Accepted flash command.
	logic err_any; // An error that still shows red.
	logic warn_any; // A pending warning.
	logic orange; // Any cause of the orange pattern.
	logic [ERR_W-1:0] err_now; // Error events of this cycle, low supply included.
	// Pattern chosen by the priority chain.
	pattern_t pat;

	// Write-one-to-clear helper; the set term wins over a clear in the same cycle.
	function automatic logic [IRQ_W-1:0] w1c(input logic [IRQ_W-1:0] cur, input logic [IRQ_W-1:0] clr,
			input logic [IRQ_W-1:0] set);
		return (cur & ~clr) | set;
	endfunction

	// One timer for all patterns; separate timers would let the colours drift apart.
	blink_timer #(.HALF_CYCLES(HALF_CYCLES)) u_blink (
		.clk(clk),
		.reset_n(reset_n),
		.phase(phase)
	);

	// Condition decode and acknowledge sources.
	always_comb begin
		// Compared every cycle; a supply hovering at the threshold only re-sets the pending error.
		low_power = supply_mv < LOW_POWER_MV;
		auto_mode = control[CTL_AUTO];
		// The button pair clears errors in either mode; warnings decide separately below.
		ack = (btn_open && btn_close) || ext_reset_in;
		wr_cmd = reg_write && (reg_addr == REG_COMMAND);
		err_now = err_event;
		err_now[ERR_LOW_POWER] = err_event[ERR_LOW_POWER] | low_power;
		err_any = |(err_pend & ~tool_acked);
		warn_any = |warn_pend;
		// tool-acknowledged heat or current faults fall back to orange.
		orange = warn_any || no_device_type || device_changed || refrun_needed || |tool_acked;
		flash_go = wr_cmd && reg_wdata[CMD_FLASH] && (!control[CTL_ACCESS_EN] || pin_ok);
	end

	// Pending errors, warnings and the latched start-up and critical conditions.
	always_comb begin
		next_err_pend = err_pend;
		next_tool_acked = tool_acked;
		next_warn_pend = warn_pend;
		if (ack) begin
			next_err_pend = '0;
			next_tool_acked = '0;
		end
		// Warnings take the button pair only in manual mode, the reset input always.
		if (ext_reset_in || (btn_open && btn_close && !auto_mode)) begin
			next_warn_pend = '0;
		end
		// Only heat and current faults take the tool acknowledge; they stay pending for the fault output.
		// A same-cycle acknowledge has already cleared the error, so nothing is left to mark.
		if (wr_cmd && reg_wdata[CMD_TOOL_ACK]) begin
			next_tool_acked[ERR_OVERTEMP] |= next_err_pend[ERR_OVERTEMP];
			next_tool_acked[ERR_OVERCURRENT] |= next_err_pend[ERR_OVERCURRENT];
		end
		// New events are set last so they survive a same-cycle acknowledge.
		next_err_pend = next_err_pend | err_now;
		next_tool_acked = next_tool_acked & ~err_now;
		next_warn_pend = next_warn_pend | warn_event;
		// Critical faults ignore every acknowledge; only a power cycle, seen here as reset, clears them.
		next_critical = critical | critical_event;
		next_startup_low = startup_low;
		if (!startup_done && low_power) begin
			next_startup_low = 1'b1;
		end
	end

	// LED pattern priority and fault output.
	always_comb begin
		if (startup_low) begin
			pat = PAT_ALT;
		end else if (critical || err_any) begin
			pat = PAT_RED;
		end else if (orange) begin
			pat = PAT_ORANGE;
		end else begin
			pat = PAT_GREEN;
		end
		// The off pattern is kept for a lamp test and is never chosen by the priority chain.
		next_red = 1'b0;
		next_green = 1'b0;
		unique case (pat)
			PAT_GREEN: next_green = phase;
			PAT_ORANGE: begin
				next_red = phase;
				next_green = phase;
			end
			PAT_RED: next_red = phase;
			PAT_ALT: begin
				next_red = phase;
				next_green = ~phase;
			end
			PAT_OFF: ;
		endcase
		// Tool-acknowledged faults still drive the output, since the tool only changes the colour.
		next_fault = auto_mode && (critical || |err_pend);
	end

	// Firmware update sequence: restart, load, then reference run.
	always_comb begin
		// The restart state lasts one cycle; the load waits for software to report success.
		next_upd = upd;
		unique case (upd)
			UPD_IDLE: if (flash_go) next_upd = UPD_RESTART;
			UPD_RESTART: next_upd = UPD_LOAD;
			UPD_LOAD: if (wr_cmd && reg_wdata[CMD_DONE_OK]) next_upd = UPD_REFRUN;
			UPD_REFRUN: next_upd = UPD_IDLE;
		endcase
	end

	// Register writes, PIN check and interrupt bookkeeping.
	always_comb begin
		next_control = control;
		next_master_pin = master_pin;
		next_pin_ok = pin_ok;
		next_irq_mask = irq_mask;
		if (reg_write) begin
			unique case (reg_addr)
				REG_CONTROL: next_control = reg_wdata;
				REG_MASTER_PIN: next_master_pin = reg_wdata;
				REG_PIN_ENTRY: next_pin_ok = (reg_wdata == master_pin);
				REG_IRQ_MASK: next_irq_mask = reg_wdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		// A PIN grants one update only.
		if (flash_go) begin
			next_pin_ok = 1'b0;
		end
		// Interrupt events, one per status bit.
		irq_set = '0;
		irq_set[IRQ_ERROR] = |err_now || critical_event;
		irq_set[IRQ_WARNING] = |warn_event;
		irq_set[IRQ_ACK] = ack;
		irq_set[IRQ_UPDATE] = upd == UPD_REFRUN;
		irq_clr = '0;
		if (reg_write && reg_addr == REG_IRQ_STATUS) begin
			irq_clr = reg_wdata[IRQ_W-1:0];
		end
		next_irq_status = w1c(irq_status, irq_clr, irq_set);
		// The master PIN is write-only, so it never appears on the read port.
		next_rdata = 16'h0000;
		if (reg_read) begin
			unique case (reg_addr)
				// Only the heat-to-current span of the tool marks can ever be set, so three bits carry them.
				REG_STATUS: next_rdata = {4'h0, critical, startup_low, warn_pend, tool_acked[ERR_OVERCURRENT:ERR_OVERTEMP], err_pend};
				REG_IRQ_STATUS: next_rdata = {12'h000, irq_status};
				REG_IRQ_MASK: next_rdata = {12'h000, irq_mask};
				REG_CONTROL: next_rdata = control;
				REG_COMMAND: next_rdata = {12'h000, upd};
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			err_pend <= '0;
			tool_acked <= '0;
			warn_pend <= '0;
			critical <= 1'b0;
			startup_low <= 1'b0;
			control <= CONTROL_RESET;
			master_pin <= MASTER_PIN_RESET;
			pin_ok <= 1'b0;
			irq_status <= '0;
			irq_mask <= IRQ_MASK_RESET;
			rdata <= 16'h0000;
			upd <= UPD_IDLE;
			red_q <= 1'b0;
			green_q <= 1'b0;
			fault_q <= 1'b0;
			restart_q <= 1'b0;
			refrun_q <= 1'b0;
		end else begin
			err_pend <= next_err_pend;
			tool_acked <= next_tool_acked;
			warn_pend <= next_warn_pend;
			critical <= next_critical;
			startup_low <= next_startup_low;
			control <= next_control;
			master_pin <= next_master_pin;
			pin_ok <= next_pin_ok;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			rdata <= next_rdata;
			upd <= next_upd;
			red_q <= next_red;
			green_q <= next_green;
			fault_q <= next_fault;
			restart_q <= (next_upd == UPD_RESTART);
			refrun_q <= (next_upd == UPD_REFRUN);
		end
	end

	// Outputs straight from flip-flops, apart from the masked interrupt.
	always_comb begin
		reg_rdata = rdata;
		led_red = red_q;
		led_green = green_q;
		fault_out = fault_q;
		fault_led = fault_q;
		// Combinational from flip-flops, so a mask write takes effect in the next cycle.
		irq = |(irq_status & irq_mask);
		restart_req = restart_q;
		refrun_start = refrun_q;
	end
endmodule

// *** dv/status_signal_chk.sv ***
// Port checker for the status LED and fault signalling block.
module status_chk #(
	parameter int HALF_CYCLES = 4
) (
	// Clock, reset and causes.
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [status_pkg::ERR_W-1:0] err_event,
	input wire logic [status_pkg::VOLT_W-1:0] supply_mv,
	input wire logic startup_done,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	// Outputs under watch.
	input wire logic led_red,
	input wire logic led_green,
	input wire logic fault_out,
	input wire logic fault_led,
	input wire logic restart_req,
	input wire logic refrun_start
);
	timeunit 1ns;
	timeprecision 1ps;
	import status_pkg::*;
	localparam int WIN = 3 * HALF_CYCLES + 3;
	int red_run;
	int green_run;
	wire flash_wr = reg_write && reg_addr == REG_COMMAND && reg_wdata[CMD_FLASH];
	wire done_wr = reg_write && reg_addr == REG_COMMAND && reg_wdata[CMD_DONE_OK];
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Lit run lengths; a stuck blink timer would let a colour stay lit past half a period.
	always_ff @(posedge clk) begin
		red_run <= (reset_n && led_red) ? red_run + 1 : 0;
		green_run <= (reset_n && led_green) ? green_run + 1 : 0;
	end
	property p_fault_led;
		fault_led == fault_out;
	endproperty
	a_fault_led: assert property (p_fault_led) else $error("fault LED differs from fault output");
	property p_restart_cause;
		restart_req |-> $past(flash_wr);
	endproperty
	a_restart_cause: assert property (p_restart_cause) else $error("restart without flash command");
	property p_restart_pulse;
		restart_req |=> !restart_req;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse too long");
	property p_refrun_cause;
		refrun_start |-> $past(done_wr);
	endproperty
	a_refrun_cause: assert property (p_refrun_cause) else $error("reference run without update done");
	property p_red_error;
		(err_event[ERR_STEP_LOSS] && startup_done) |-> ##[1:WIN] (led_red && !led_green);
	endproperty
	a_red_error: assert property (p_red_error) else $error("error did not show red");
	property p_alt;
		(!startup_done && supply_mv < LOW_POWER_MV) |-> ##[2:WIN] (led_red ^ led_green);
	endproperty
	a_alt: assert property (p_alt) else $error("start-up low supply not alternating");
	property p_red_run;
		red_run <= HALF_CYCLES;
	endproperty
	a_red_run: assert property (p_red_run) else $error("red lit beyond half period");
	property p_green_run;
		green_run <= HALF_CYCLES;
	endproperty
	a_green_run: assert property (p_green_run) else $error("green lit beyond half period");
endmodule

bind status_signal status_chk #(.HALF_CYCLES(HALF_CYCLES)) u_status_chk (.clk(clk), .reset_n(reset_n),
	.err_event(err_event), .supply_mv(supply_mv), .startup_done(startup_done), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .led_red(led_red), .led_green(led_green),
	.fault_out(fault_out), .fault_led(fault_led), .restart_req(restart_req), .refrun_start(refrun_start));

// *** dv/op_panel.sv ***
// Operator buttons and master control reset line in front of the card.
module op_panel #(
	parameter int HOLD = 3
) (
	// Clock and requests from the bench.
	input wire logic clk,
	input wire logic ack_btn,
	input wire logic ack_ext,
	// Pins towards the card.
	output logic btn_open,
	output logic btn_close,
	output logic ext_reset_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int n_btn = 0;
	int n_ext = 0;
	// A person never hits both buttons at once, so Close lands one cycle after Open.
	always @(posedge clk) begin
		n_btn <= ack_btn ? HOLD + 1 : (n_btn > 0 ? n_btn - 1 : 0);
		n_ext <= ack_ext ? HOLD : (n_ext > 0 ? n_ext - 1 : 0);
		btn_open <= n_btn > 0;
		btn_close <= n_btn > 0 && n_btn <= HOLD;
		ext_reset_in <= n_ext > 0;
	end
endmodule

// *** dv/tb_status_signal.sv ***
// Self-checking bench for the status LED and fault signalling block.
module tb_status_signal;
	timeunit 1ns;
	timeprecision 1ps;
	import status_pkg::*;
	localparam int HALF = 4;
	localparam logic [2:0] G = 3'h1, R = 3'h2, O = 3'h4, A = 3'h3;
	typedef struct packed {logic [4:0] err; logic [1:0] warn; logic [2:0] lvl; logic [2:0] exp;} row_t;
	row_t rows [12] = '{'{5'h00, 2'h0, 3'h0, G}, '{5'h01, 2'h0, 3'h0, R}, '{5'h02, 2'h0, 3'h0, R},
		'{5'h04, 2'h0, 3'h0, R}, '{5'h08, 2'h0, 3'h0, R}, '{5'h10, 2'h0, 3'h0, R}, '{5'h00, 2'h1, 3'h0, O},
		'{5'h00, 2'h2, 3'h0, O}, '{5'h00, 2'h0, 3'h1, O}, '{5'h00, 2'h0, 3'h2, O}, '{5'h00, 2'h0, 3'h4, O},
		'{5'h01, 2'h1, 3'h1, R}};
	logic clk = 1'b0, reset_n = 1'b0, ack_btn = 1'b0, ack_ext = 1'b0, critical_event = 1'b0;
	logic startup_done = 1'b1, no_device_type = 1'b0, device_changed = 1'b0, refrun_needed = 1'b0;
	logic reg_write = 1'b0, reg_read = 1'b0;
	logic [4:0] err_event = 5'h00;
	logic [1:0] warn_event = 2'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] supply_mv = 16'h2AF8, reg_wdata = 16'h0000, reg_rdata, d;
	logic led_red, led_green, fault_out, fault_led, irq, restart_req, refrun_start, btn_open, btn_close, ext_reset_in;
	logic [2:0] c;
	int errors = 0, checks_done = 0, n_rst = 0, n_ref = 0;
	status_signal #(.HALF_CYCLES(HALF)) u_status_signal (.clk(clk), .reset_n(reset_n), .btn_open(btn_open),
		.btn_close(btn_close), .ext_reset_in(ext_reset_in), .err_event(err_event), .warn_event(warn_event),
		.critical_event(critical_event), .supply_mv(supply_mv), .startup_done(startup_done),
		.no_device_type(no_device_type), .device_changed(device_changed), .refrun_needed(refrun_needed),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .led_red(led_red), .led_green(led_green), .fault_out(fault_out),
		.fault_led(fault_led), .irq(irq), .restart_req(restart_req), .refrun_start(refrun_start));
	op_panel u_op_panel (.clk(clk), .ack_btn(ack_btn), .ack_ext(ack_ext), .btn_open(btn_open),
		.btn_close(btn_close), .ext_reset_in(ext_reset_in));
	// Clock, watchdog and pulse counters.
	initial begin
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report;
	end
	always @(posedge clk) begin
		if (restart_req === 1'b1) n_rst++;
		if (refrun_start === 1'b1) n_ref++;
	end
	task automatic final_report;
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic hit(input logic [4:0] e, input logic [1:0] w, input logic k);
		@(posedge clk);
		err_event <= e;
		warn_event <= w;
		critical_event <= k;
		@(posedge clk);
		err_event <= 5'h00;
		warn_event <= 2'h0;
		critical_event <= 1'b0;
	endtask
	task automatic ack(input logic ext);
		@(posedge clk);
		ack_ext <= ext;
		ack_btn <= !ext;
		@(posedge clk);
		ack_ext <= 1'b0;
		ack_btn <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	// Watches a full blink period and notes which colours were shown.
	task automatic color(output logic [2:0] k);
		k = 3'h0;
		repeat (3) @(posedge clk);
		repeat (2 * HALF + 2) begin
			@(posedge clk);
			#1 k = k | {led_red & led_green, led_red & ~led_green, ~led_red & led_green};
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk);
			{no_device_type, device_changed, refrun_needed} <= rows[i].lvl;
			hit(rows[i].err, rows[i].warn, 1'b0);
			color(c);
			chk("row colour", 16'(rows[i].exp), 16'(c));
			@(posedge clk);
			{no_device_type, device_changed, refrun_needed} <= 3'h0;
			ack(i[0]);
			color(c);
			chk("cleared colour", 16'(G), 16'(c));
		end
		// A heat error raises the fault output and turns orange once tool-acknowledged.
		wr(REG_CONTROL, 16'h0001);
		hit(5'h02, 2'h0, 1'b0);
		@(posedge clk);
		#1 chk("fault out", 16'h0001, 16'(fault_out));
		wr(REG_COMMAND, 16'h0004);
		color(c);
		chk("acked colour", 16'(O), 16'(c));
		ack(1'b0);
		chk("fault cleared", 16'h0000, 16'(fault_out));
		// In automatic mode the button pair leaves a warning standing; the reset input clears it.
		hit(5'h00, 2'h1, 1'b0);
		ack(1'b0);
		color(c);
		chk("auto warn kept", 16'(O), 16'(c));
		ack(1'b1);
		color(c);
		chk("auto warn cleared", 16'(G), 16'(c));
		// Interrupt raised, masked and cleared.
		wr(REG_IRQ_STATUS, 16'h000F);
		rd(REG_IRQ_STATUS, d);
		chk("irq status", 16'h0000, d);
		chk("irq idle", 16'h0000, 16'(irq));
		hit(5'h01, 2'h0, 1'b0);
		rd(REG_IRQ_STATUS, d);
		chk("irq error bit", 16'h0001, d & 16'h0001);
		chk("irq masked off", 16'h0000, 16'(irq));
		wr(REG_IRQ_MASK, 16'h000F);
		chk("irq mask", 16'h0001, 16'(irq));
		rd(REG_IRQ_MASK, d);
		chk("mask readback", 16'h000F, d);
		wr(REG_IRQ_STATUS, 16'h0001);
		rd(REG_IRQ_STATUS, d);
		chk("irq w1c", 16'h0000, d & 16'h0001);
		rd(4'hF, d);
		chk("unmapped read", 16'h0000, d);
		ack(1'b1);
		// One millivolt under the threshold is an error.
		@(posedge clk);
		supply_mv <= 16'h2AF7;
		repeat (2) @(posedge clk);
		supply_mv <= 16'h2AF8;
		color(c);
		chk("low supply colour", 16'(R), 16'(c));
		ack(1'b1);
		// Update refused without the PIN, then restart and reference run.
		wr(REG_CONTROL, 16'h0003);
		wr(REG_COMMAND, 16'h0001);
		repeat (4) @(posedge clk);
		chk("restart without pin", 16'h0000, 16'(n_rst));
		wr(REG_MASTER_PIN, 16'hA5C3);
		wr(REG_PIN_ENTRY, 16'hA5C3);
		wr(REG_COMMAND, 16'h0001);
		rd(REG_COMMAND, d);
		chk("update state", 16'h0004, d);
		chk("restart pulses", 16'h0001, 16'(n_rst));
		wr(REG_COMMAND, 16'h0002);
		repeat (4) @(posedge clk);
		chk("reference run pulses", 16'h0001, 16'(n_ref));
		// A critical error survives both acknowledge paths.
		hit(5'h00, 2'h0, 1'b1);
		ack(1'b1);
		ack(1'b0);
		color(c);
		chk("critical colour", 16'(R), 16'(c));
		chk("critical fault", 16'h0001, 16'(fault_out));
		// Power cycle with a low supply during start-up.
		@(posedge clk);
		reset_n <= 1'b0;
		startup_done <= 1'b0;
		supply_mv <= 16'h2AF7;
		repeat (4) @(posedge clk);
		chk("leds in reset", 16'h0000, 16'({led_red, led_green, fault_out, fault_led}));
		chk("pulses in reset", 16'h0000, 16'({irq, restart_req, refrun_start}));
		chk("read data in reset", 16'h0000, reg_rdata);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		startup_done <= 1'b1;
		supply_mv <= 16'h2AF8;
		color(c);
		chk("start-up colour", 16'(A), 16'(c));
		chk("fault after power cycle", 16'h0000, 16'(fault_out));
		rd(REG_STATUS, d);
		chk("critical after power cycle", 16'h0000, d & 16'h0800);
		chk("start-up latch", 16'h0400, d & 16'h0400);
		final_report;
	end
endmodule
